// ==== hdl/fps_pkg.sv ====
// constants, states and carriers of the flash program/status sequencer
package fps_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_NS = 100;
   localparam int READY_MAX_NS = 11000;
   localparam int READY2_MIN_NS = 500;
   localparam int STANDBY_MIN_NS = 20000;
   localparam int BUSY_MAX_NS = 90;
   localparam int PROG_TYP_NS = 9000;
   localparam longint ERASE_TYP_NS = 64'd500000000;
   localparam int READY_MAX_CYC = (READY_MAX_NS / CLK_NS) < 1 ? 1 : READY_MAX_NS / CLK_NS;
   localparam int READY2_CYC = (READY2_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int STANDBY_CYC = (STANDBY_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int BUSY_CYC = (BUSY_MAX_NS / CLK_NS) < 1 ? 1 : BUSY_MAX_NS / CLK_NS;
   localparam int PROG_CYC = PROG_TYP_NS / CLK_NS;
   localparam int ERASE_CYC = int'(ERASE_TYP_NS / CLK_NS);
   // ----------------------------------------
   // command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_RESET = 8'hf0;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_ERASE = 8'h30;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [7:0] CMD_PROTECT = 8'h68;
   localparam logic [7:0] CMD_UNPROTECT = 8'h60;
   localparam logic [7:0] CMD_PROT_VERIFY = 8'h48;
   localparam logic [7:0] CMD_UNPROT_VERIFY = 8'h40;
   localparam logic [7:0] PROT_ADDR = 8'h3a;
   localparam int SECT_LSB = 14;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int TOG_BIT = 6;
   localparam int SUS_BIT = 2;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [5:0] {
      FPS_IDLE = 6'b000001,
      FPS_PROG = 6'b000010,
      FPS_ERASE = 6'b000100,
      FPS_SUSP = 6'b001000,
      FPS_RSTREC = 6'b010000,
      FPS_STBY = 6'b100000
   } fps_state_e;
   typedef enum logic [2:0] {
      FPS_OP_NONE = 3'h0,
      FPS_OP_PROTECT = 3'h1,
      FPS_OP_UNPROTECT = 3'h2,
      FPS_OP_PVERIFY = 3'h3,
      FPS_OP_UVERIFY = 3'h4
   } fps_op_e;
   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } fps_cmd_s;
   typedef struct packed {
      logic strobe;
      logic [ADDR_W-1:0] addr;
   } fps_rd_s;
endpackage

// ==== hdl/fps_timer.sv ====
// down-counter timing embedded algorithms and reset recovery
`timescale 1ns/1ps
module fps_timer #(
   parameter int CNT_W = 23
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // control
   input wire logic load,
   input wire logic [CNT_W-1:0] loadVal,
   input wire logic hold,
   // status
   output logic done
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic done;
   } fps_tmr_s;
   fps_tmr_s st_q, st_d;

   initial begin
      if (CNT_W < 2) begin
         $error("fps_timer: counter must be at least two bits");
      end
   end

   always_comb begin
      st_d = st_q;
      st_d.done = 1'b0;
      if (load) begin
         st_d.cnt = loadVal;
      end else if (!hold && st_q.cnt != '0) begin
         st_d.cnt = st_q.cnt - 1'b1;
         st_d.done = (st_q.cnt == {{(CNT_W-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign done = st_q.done;
endmodule

// ==== hdl/fps_sequencer.sv ====
// embedded program/erase sequencer with status toggling and reset recovery
`timescale 1ns/1ps
module fps_sequencer
   import fps_pkg::*;
#(
   parameter int PROG_CYCLES = fps_pkg::PROG_CYC,
   parameter int ERASE_CYCLES = fps_pkg::ERASE_CYC,
   parameter int ABORT_CYCLES = fps_pkg::READY_MAX_CYC,
   parameter int STANDBY_CYCLES = fps_pkg::STANDBY_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // flash bus, already decoded into command and read strobes
   input wire fps_pkg::fps_cmd_s cmdIn,
   input wire fps_pkg::fps_rd_s rdIn,
   input wire logic [fps_pkg::DATA_W-1:0] arrayData,
   // pins from outside the clock domain
   input wire logic hwResetN,
   input wire logic burstEnable,
   input wire logic readyTimingSelect,
   // outputs
   output logic readyBusyOut,
   output logic [fps_pkg::DATA_W-1:0] readData,
   output logic readyOut,
   output logic singleAccess,
   output logic standbyOut,
   output fps_pkg::fps_op_e protOp
);
   import fps_pkg::*;

   initial begin
      if (PROG_CYCLES < 1 || ERASE_CYCLES < 1 || ABORT_CYCLES < 1 || STANDBY_CYCLES < 1) begin
         $error("fps_sequencer: cycle counts must be at least one");
      end
      // the shared timer is 23 bits wide, longer counts would wrap
      if (PROG_CYCLES >= 8388608 || ERASE_CYCLES >= 8388608 || ABORT_CYCLES >= 8388608
          || STANDBY_CYCLES >= 8388608) begin
         $error("fps_sequencer: cycle counts must fit the timer");
      end
   end

   localparam int CW = 23;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      fps_state_e state;
      logic [2:0] rstSync;
      logic [1:0] burstSync;
      logic [1:0] rtsSync;
      logic busyN;
      logic primTog;
      logic susTog;
      logic [ADDR_W-1:SECT_LSB] susSect;
      logic [ADDR_W-1:SECT_LSB] eraseSect;
      logic [DATA_W-1:0] rdData;
      logic rdValid;
      logic rdyOut;
      logic singleOne;
      logic single;
      logic wasAlgo;
      logic [CW-1:0] rstCnt;
      logic stby;
      fps_op_e op;
   } fps_seq_s;
   fps_seq_s s_q, s_d;

   logic tmrLoad, tmrDone, tmrHold;
   logic [CW-1:0] tmrVal;

   function automatic logic inSect(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:SECT_LSB] sect);
      inSect = (a[ADDR_W-1:SECT_LSB] == sect);
   endfunction

   // mode-independent algorithm timing
   // one timer serves both modes, so program/erase timing cannot depend on mode
   fps_timer #(.CNT_W(CW)) u_timer (
      .core_clk(core_clk),
      .rst(rst),
      .load(tmrLoad),
      .loadVal(tmrVal),
      .hold(tmrHold),
      .done(tmrDone)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic rstLow, algo, dataReady;
      rstLow = 1'b0;
      algo = 1'b0;
      dataReady = 1'b0;
      s_d = s_q;
      tmrLoad = 1'b0;
      tmrVal = '0;
      tmrHold = 1'b0;
      s_d.rstSync = {s_q.rstSync[1:0], hwResetN};
      s_d.burstSync = {s_q.burstSync[0], burstEnable};
      s_d.rtsSync = {s_q.rtsSync[0], readyTimingSelect};
      rstLow = !s_q.rstSync[2];
      algo = (s_q.state == FPS_PROG) || (s_q.state == FPS_ERASE);
      s_d.rdValid = 1'b0;
      s_d.op = FPS_OP_NONE;
      if (rstLow) begin
         if (s_q.rstCnt != CW'(STANDBY_CYCLES)) begin
            s_d.rstCnt = s_q.rstCnt + 1'b1;
         end
         s_d.stby = (s_q.rstCnt >= CW'(STANDBY_CYCLES - 1));
         if (algo) begin
            s_d.wasAlgo = 1'b1;
         end
         s_d.state = FPS_RSTREC;
         s_d.busyN = 1'b0;
         tmrHold = 1'b1;
      end else if (s_q.state == FPS_RSTREC) begin
         s_d.stby = 1'b0;
         s_d.rstCnt = '0;
         tmrLoad = 1'b1;
         tmrVal = s_q.wasAlgo ? CW'(ABORT_CYCLES) : CW'(READY2_CYC);
         s_d.wasAlgo = 1'b0;
         s_d.state = FPS_STBY;
      end else if (s_q.state == FPS_STBY) begin
         if (tmrDone) begin
            s_d.state = FPS_IDLE;
            s_d.busyN = 1'b1;
         end
      end else begin
         // one command strobe regardless of interface mode
         if (cmdIn.valid) begin
            // protect and unprotect at low address 3ah
            if (cmdIn.addr[7:0] == PROT_ADDR && cmdIn.data == CMD_PROTECT) begin
               s_d.op = FPS_OP_PROTECT;
            end else if (cmdIn.addr[7:0] == PROT_ADDR && cmdIn.data == CMD_UNPROTECT) begin
               s_d.op = FPS_OP_UNPROTECT;
            end else if (cmdIn.data == CMD_PROT_VERIFY) begin
               s_d.op = FPS_OP_PVERIFY;
            end else if (cmdIn.data == CMD_UNPROT_VERIFY) begin
               s_d.op = FPS_OP_UVERIFY;
            end else if (cmdIn.data == CMD_RESET && !algo) begin
               // next read is a single access
               s_d.singleOne = 1'b1;
               s_d.state = FPS_IDLE;
            end else if (s_q.state == FPS_IDLE && cmdIn.data == CMD_PROGRAM) begin
               // busy on the next edge after the final strobe
               s_d.state = FPS_PROG;
               s_d.busyN = 1'b0;
               tmrLoad = 1'b1;
               tmrVal = CW'(PROG_CYCLES);
            end else if (s_q.state == FPS_IDLE && cmdIn.data == CMD_ERASE) begin
               s_d.state = FPS_ERASE;
               s_d.busyN = 1'b0;
               s_d.eraseSect = cmdIn.addr[ADDR_W-1:SECT_LSB];
               tmrLoad = 1'b1;
               tmrVal = CW'(ERASE_CYCLES);
            end else if (s_q.state == FPS_ERASE && cmdIn.data == CMD_SUSPEND) begin
               s_d.state = FPS_SUSP;
               s_d.busyN = 1'b1;
               s_d.susSect = s_q.eraseSect;
            end else if (s_q.state == FPS_SUSP && cmdIn.data == CMD_RESUME) begin
               s_d.state = FPS_ERASE;
               s_d.busyN = 1'b0;
            end
         end
         tmrHold = (s_q.state == FPS_SUSP);
         if (algo && tmrDone) begin
            s_d.state = FPS_IDLE;
            s_d.busyN = 1'b1;
         end
         if (rdIn.strobe) begin
            s_d.rdValid = 1'b1;
            s_d.rdData = arrayData;
            if (algo && !tmrDone) begin
               s_d.primTog = !s_q.primTog;
               s_d.rdData[TOG_BIT] = !s_q.primTog;
               s_d.rdData[SUS_BIT] = s_q.susTog;
            end else if (s_q.state == FPS_SUSP && inSect(rdIn.addr, s_q.susSect)) begin
               // suspend bit only in suspended sector
               s_d.susTog = !s_q.susTog;
               s_d.rdData[SUS_BIT] = !s_q.susTog;
               s_d.rdData[TOG_BIT] = s_q.primTog;
            end
            if (s_q.singleOne) begin
               s_d.singleOne = 1'b0;
            end
            s_d.single = s_q.singleOne || !s_q.burstSync[1];
         end
      end
      // ready with data or one clock after it
      dataReady = s_q.rtsSync[1] ? rdIn.strobe : s_q.rdValid;
      s_d.rdyOut = dataReady && !rstLow;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '{state: FPS_IDLE, rstSync: 3'h7, busyN: 1'b1, op: FPS_OP_NONE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign readyBusyOut = s_q.busyN;
   assign readData = s_q.rdData;
   assign readyOut = s_q.rdyOut;
   assign singleAccess = s_q.single;
   assign standbyOut = s_q.stby;
   assign protOp = s_q.op;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic algo_c;
   assign algo_c = (s_q.state == FPS_PROG) || (s_q.state == FPS_ERASE);
   chk_busy_after_cmd: assert property (@(posedge core_clk) disable iff (rst)
      (s_q.state == FPS_IDLE && cmdIn.valid && cmdIn.data == CMD_PROGRAM && s_q.rstSync[2])
      |=> !readyBusyOut) else $error("busy not raised after program command");
   chk_toggle_flip: assert property (@(posedge core_clk) disable iff (rst)
      (s_q.state == FPS_PROG && rdIn.strobe && !tmrDone && s_q.rstSync[2])
      |=> readData[TOG_BIT] != $past(s_q.primTog)) else $error("primary toggle did not invert");
   chk_suspend_outside: assert property (@(posedge core_clk) disable iff (rst)
      (s_q.state == FPS_SUSP && rdIn.strobe && !inSect(rdIn.addr, s_q.susSect))
      |=> $stable(s_q.susTog)) else $error("suspend bit toggled outside sector");
   chk_done_ready: assert property (@(posedge core_clk) disable iff (rst)
      (algo_c && tmrDone && s_q.rstSync[2]) |=> readyBusyOut && s_q.state == FPS_IDLE)
      else $error("completion did not release busy");
   chk_idle_recovery: assert property (@(posedge core_clk) disable iff (rst)
      (s_q.state == FPS_RSTREC && s_q.rstSync[2] && !s_q.wasAlgo) |=> ##[1:7] readyBusyOut)
      else $error("idle reset recovery too slow");
   chk_rdy_timing: assert property (@(posedge core_clk) disable iff (rst)
      (!s_q.rtsSync[1] && $rose(s_q.rdValid) && s_q.rstSync[2] && s_q.rtsSync[0]==s_q.rtsSync[1])
      |=> readyOut) else $error("ready not aligned with data");
   chk_protect_code: assert property (@(posedge core_clk) disable iff (rst)
      (cmdIn.valid && cmdIn.addr[7:0] == PROT_ADDR && cmdIn.data == CMD_PROTECT && s_q.rstSync[2]
       && s_q.state != FPS_RSTREC && s_q.state != FPS_STBY) |=> protOp == FPS_OP_PROTECT)
      else $error("protect command not decoded");
   chk_single_access: assert property (@(posedge core_clk) disable iff (rst)
      (s_q.singleOne && rdIn.strobe && s_q.rstSync[2] && s_q.state == FPS_IDLE)
      |=> singleAccess && !s_q.singleOne) else $error("single access missing after reset command");
endmodule

// ==== tb/fps_host_model.sv ====
// host model driving decoded command and read strobes
`timescale 1ns/1ps
module fps_host_model
   import fps_pkg::*;
(
   // clock
   input wire logic core_clk,
   // towards the device
   output fps_pkg::fps_cmd_s cmdOut,
   output fps_pkg::fps_rd_s rdOut
);
   initial begin
      cmdOut = '0;
      rdOut = '0;
   end
   task automatic send_cmd(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      cmdOut <= '{1'b1, a, d};
      @(posedge core_clk);
      // released lines show the inverse, never the stale value
      cmdOut <= '{1'b0, ~a, ~d};
      #1;
   endtask
   task automatic do_read(input logic [ADDR_W-1:0] a);
      @(posedge core_clk);
      rdOut <= '{1'b1, a};
      @(posedge core_clk);
      rdOut <= '{1'b0, ~a};
      #1;
   endtask
endmodule

// ==== tb/test_flash_program_status_reset.sv ====
// self-checking bench of the program/status sequencer
`timescale 1ns/1ps
module test_flash_program_status_reset;
   import fps_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic hwResetN = 1'b1;
   logic burstEnable = 1'b0;
   logic readyTimingSelect = 1'b0;
   logic [DATA_W-1:0] arrayData = 32'h0;
   fps_cmd_s cmdIn;
   fps_rd_s rdIn;
   logic readyBusyOut, readyOut, singleAccess, standbyOut;
   logic [DATA_W-1:0] readData;
   fps_op_e protOp;
   int miscompares = 0;
   int comparisons = 0;
   int n, m;
   logic t1;
   logic [7:0] codes [4] = '{CMD_PROTECT, CMD_UNPROTECT, CMD_PROT_VERIFY, CMD_UNPROT_VERIFY};
   always #50 core_clk = ~core_clk;
   // shortened erase and standby counts keep the run brief
   fps_sequencer #(.ERASE_CYCLES(200), .STANDBY_CYCLES(20)) fps_sequencer_inst (
      .core_clk(core_clk), .rst(rst), .cmdIn(cmdIn), .rdIn(rdIn), .arrayData(arrayData),
      .hwResetN(hwResetN), .burstEnable(burstEnable), .readyTimingSelect(readyTimingSelect),
      .readyBusyOut(readyBusyOut), .readData(readData), .readyOut(readyOut),
      .singleAccess(singleAccess), .standbyOut(standbyOut), .protOp(protOp)
   );
   fps_host_model fps_host_model_inst (.core_clk(core_clk), .cmdOut(cmdIn), .rdOut(rdIn));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic rd(input logic [19:0] a, input logic [31:0] d);
      arrayData <= d;
      fps_host_model_inst.do_read(a);
   endtask
   task automatic wait_ready(output int k);
      k = 0;
      while (readyBusyOut !== 1'b1 && k < 1000) begin
         cyc(1);
         k++;
      end
   endtask
   task automatic pin_reset(input int k, input logic sb);
      @(posedge core_clk);
      hwResetN <= 1'b0;
      cyc(k);
      check(readyBusyOut, 0);
      check(standbyOut, sb);
      @(posedge core_clk);
      hwResetN <= 1'b1;
      #1;
      wait_ready(m);
   endtask
   task automatic run_prog(output int k);
      fps_host_model_inst.send_cmd(20'h00100, CMD_PROGRAM);
      check(readyBusyOut, 0);
      rd(20'h00100, 32'h0);
      t1 = readData[TOG_BIT];
      rd(20'h08104, 32'h0);
      check(readData[TOG_BIT], !t1);
      wait_ready(k);
      k += 4;
   endtask
   task automatic finish_test();
      $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      #3000000;
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      cyc(1);
      check({readyBusyOut, readyOut, singleAccess, standbyOut}, 4'b1000);
      foreach (codes[i]) begin
         fps_host_model_inst.send_cmd({12'h000, PROT_ADDR}, codes[i]);
         check(protOp, i + 1);
      end
      fps_host_model_inst.send_cmd(20'h00055, CMD_PROTECT);
      check(protOp, FPS_OP_NONE);
      burstEnable <= 1'b1;
      cyc(3);
      fps_host_model_inst.send_cmd(20'h0, CMD_RESET);
      rd(20'h00200, 32'h1234abcd);
      check(singleAccess, 1);
      check(readData, 32'h1234abcd);
      rd(20'h00204, 32'h0f0f0f0f);
      check(singleAccess, 0);
      for (int s = 0; s < 2; s++) begin
         readyTimingSelect <= s[0];
         cyc(4);
         rd(20'h00300, 32'h5a5a5a5a);
         check(readyOut, s[0]);
         cyc(1);
         check(readyOut, !s[0]);
      end
      // same duration with burst on and off
      run_prog(n);
      burstEnable <= 1'b0;
      cyc(3);
      run_prog(m);
      check(n >= 85 && n <= 95, 1);
      check(m, n);
      rd(20'h00100, 32'hcafe0001);
      check(readData, 32'hcafe0001);
      rd(20'h00100, 32'hcafe0002);
      check(readData, 32'hcafe0002);
      // erase in sector 3, then suspend it
      fps_host_model_inst.send_cmd(20'h0c000, CMD_ERASE);
      fps_host_model_inst.send_cmd(20'h0c000, CMD_SUSPEND);
      cyc(2);
      rd(20'h0c010, 32'h0);
      t1 = readData[SUS_BIT];
      rd(20'h0c010, 32'h0);
      check(readData[SUS_BIT], !t1);
      rd(20'h10010, 32'h0);
      t1 = readData[SUS_BIT];
      rd(20'h10010, 32'h0);
      check(readData[SUS_BIT], t1);
      fps_host_model_inst.send_cmd(20'h0c000, CMD_RESUME);
      wait_ready(n);
      check(n >= 180 && n <= 205, 1);
      pin_reset(10, 1'b0);
      check(m >= 5 && m <= 12, 1);
      pin_reset(30, 1'b1);
      check(standbyOut, 0);
      // abort a running program
      fps_host_model_inst.send_cmd(20'h00100, CMD_PROGRAM);
      cyc(10);
      pin_reset(10, 1'b0);
      check(m >= 105 && m <= 118, 1);
      finish_test();
   end
endmodule
